// ===== hdl/dppg_pkg.sv
// constants, register map and types for the dual unit interlocked rectangular wave timer
// Operation
// [R1] phase compare register bits 16..0 hold phase value; bits 31..17 read zero
// [R2] phase compare register loads only from writable timer register five
// [R3] software keeps each unit prescaler clock at or below the maximum rate
// [R4] interlocked: unit one ignores own prescaler select, uses unit zero select
// [R5] unit zero: one 16-bit counter, six comparators, two output channels
// [R6] unit one: one 16-bit counter, five comparators, two output channels
// [R7] each counter is a 16-bit up-counter stepping once per prescaler tick
// [R8] run bit zero clears and halts the counter; one starts counting
// [R9] clear enable zero: counter runs free and wraps
// [R10] clear enable one: counter cleared on comparator zero match
// [R11] interlocked: unit one cleared by unit zero phase comparator match
// [R12] comparator zero sets the counting period
// [R13] comparators one and three set leading edges of wave outputs
// [R14] comparators two and four set trailing edges of wave outputs
// [R15] unit zero comparator five sets phase between the two units
// [R16] buffer mode zero: timer register write also writes compare register
// [R17] compare registers read-only; change only through their timer registers
// [R18] buffer mode one with update flag: timer copied to compare at update timing
// [R19] comparators two and four: match delayed one clock when modulation asks
// [R20] compare registers two and four hold 4-bit modulation rate in bits 3..0
// [R21] buffered transfer happens at period end, then update flag clears
// [R22] each comparator pulses one cycle on equality while counter runs
package dppg_pkg;
	localparam int UNITS = 2;
	localparam int CMP_MAX = 6;
	localparam int CNT_W = 16;
	localparam int RG_W = 20;
	localparam int SEL_W = 4;
	localparam int RATE_W = 4;
	localparam int IDX_W = 3;
	localparam int ADDR_W = 12;

	// byte offsets inside one unit window, global register address and unit select bit
	localparam logic [7:0] OFF_RUN = 8'h00;
	localparam logic [7:0] OFF_MOD = 8'h04;
	localparam logic [7:0] OFF_CR = 8'h08;
	localparam logic [2:0] BLK_RG = 3'h1;
	localparam logic [2:0] BLK_CP = 3'h2;
	localparam logic [11:0] OFF_GLB = 12'h200;
	localparam int UNIT_BIT = 8;

	// field positions
	localparam int RUN_BIT = 0;
	localparam int CLE_BIT = 4;
	localparam int SEL_LSB = 0;
	localparam int BUFM_BIT = 0;
	localparam int UPD_BIT = 1;
	localparam int ILK_BIT = 0;
	localparam int TIM_LSB_MOD = 4;

	// per comparator stored widths and indices
	localparam logic [19:0] MASK_PLAIN = 20'h0FFFF;
	localparam logic [19:0] MASK_MOD = 20'hFFFFF;
	localparam logic [19:0] MASK_PHASE = 20'h1FFFF;
	localparam int CMP_PERIOD = 0;
	localparam int CMP_PHASE = 5;
	localparam logic [IDX_W-1:0] UNIT1_LAST = 3'h4;
	localparam logic [IDX_W-1:0] UNIT0_LAST = 3'h5;

	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef struct packed {
		logic run;
		logic cle;
		logic bufm;
		logic upd;
		logic [SEL_W-1:0] sel;
	} dppg_ctl_t;

	localparam dppg_ctl_t CTL_RST = '{run: 1'b0, cle: 1'b0, bufm: 1'b0, upd: 1'b0, sel: 4'h0};
endpackage : dppg_pkg

// ===== hdl/dppg_timer.sv
// dual unit interlocked rectangular wave timer with apb register slave
`timescale 1ns/100ps
module dppg_timer #(
	parameter int CNT_W = dppg_pkg::CNT_W
) (
	input wire logic core_clk_i, // 40 MHz core clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic psel_i, // apb select
	input wire logic penable_i, // apb enable
	input wire logic pwrite_i, // apb direction, high for write
	input wire logic [dppg_pkg::ADDR_W-1:0] paddr_i, // apb byte address
	input wire logic [31:0] pwdata_i, // apb write data
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error on unmapped address
	output logic [3:0] wave_o // unit0 ch0, ch1, unit1 ch0, ch1
);
	dppg_pkg::dppg_ctl_t ctl_reg [0:1];
	logic ilk_reg;
	logic [19:0] rg_reg [0:1][0:5];
	logic [19:0] cp_reg [0:1][0:5];
	logic [CNT_W-1:0] cnt_reg [0:1];
	logic [CNT_W-1:0] pre_reg [0:1];
	logic [1:0] wave_reg [0:1];
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;

	logic tick [0:1];
	logic match [0:1][0:5];
	logic clr_match [0:1];
	logic period_end [0:1];
	logic xfer [0:1];

	// address decode
	wire [7:0] off = paddr_i[7:0];
	wire unit_sel = paddr_i[dppg_pkg::UNIT_BIT];
	wire in_units = (paddr_i[11:9] == 3'h0);
	wire [dppg_pkg::IDX_W-1:0] idx = off[4:2];
	wire [dppg_pkg::IDX_W-1:0] last_idx = unit_sel ? dppg_pkg::UNIT1_LAST : dppg_pkg::UNIT0_LAST;
	wire idx_ok = (off[1:0] == 2'h0) && (idx <= last_idx);
	wire hit_run = in_units && (off == dppg_pkg::OFF_RUN);
	wire hit_mod = in_units && (off == dppg_pkg::OFF_MOD);
	wire hit_cr = in_units && (off == dppg_pkg::OFF_CR);
	wire hit_rg = in_units && (off[7:5] == dppg_pkg::BLK_RG) && idx_ok;
	wire hit_cp = in_units && (off[7:5] == dppg_pkg::BLK_CP) && idx_ok;
	wire hit_glb = (paddr_i == dppg_pkg::OFF_GLB);
	wire mapped = hit_run || hit_mod || hit_cr || hit_rg || hit_cp || hit_glb;

	// a write takes effect only at the access edge with ready high
	wire acc = psel_i && penable_i && pready_reg;
	wire wr = acc && pwrite_i && !pslverr_reg;
	wire setup = psel_i && !penable_i;

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = dppg_pkg::RST_WORD;
		if (hit_glb) begin
			rd_mux[dppg_pkg::ILK_BIT] = ilk_reg;
		end else if (hit_run) begin
			rd_mux[dppg_pkg::RUN_BIT] = ctl_reg[unit_sel].run;
		end else if (hit_mod) begin
			rd_mux[dppg_pkg::CLE_BIT] = ctl_reg[unit_sel].cle;
			rd_mux[dppg_pkg::SEL_LSB +: dppg_pkg::SEL_W] = ctl_reg[unit_sel].sel;
		end else if (hit_cr) begin
			rd_mux[dppg_pkg::BUFM_BIT] = ctl_reg[unit_sel].bufm;
			rd_mux[dppg_pkg::UPD_BIT] = ctl_reg[unit_sel].upd;
		end else if (hit_rg) begin
			rd_mux[19:0] = rg_reg[unit_sel][idx];
		end else if (hit_cp) begin
			rd_mux[19:0] = cp_reg[unit_sel][idx]; // R1
		end
	end

	// zero wait state slave: ready raised at the edge that ends the setup cycle, answer ready at the first access edge
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= dppg_pkg::RST_WORD;
		end else begin
			pready_reg <= setup;
			pslverr_reg <= setup && !mapped;
			prdata_reg <= (setup && !pwrite_i && mapped) ? rd_mux : dppg_pkg::RST_WORD;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ilk_reg <= 1'b0;
		end else if (wr && hit_glb) begin
			ilk_reg <= pwdata_i[dppg_pkg::ILK_BIT];
		end
	end

	genvar u, m;
	generate
		for (u = 0; u < dppg_pkg::UNITS; u++) begin : g_unit
			localparam int NCMP = (u == 0) ? 6 : 5; // R5 R6
			wire wsel = wr && (unit_sel == 1'(u));
			wire [CNT_W-1:0] pre_mask;
			wire own_tick;

			// prescaler divides by two to the power of the select field
			assign pre_mask = CNT_W'((32'h1 << ctl_reg[u].sel) - 32'h1);
			assign own_tick = ((pre_reg[u] & pre_mask) == pre_mask);
			if (u == 1) begin : g_ilk_tick
				assign tick[u] = ilk_reg ? tick[0] : own_tick; // R4
				assign clr_match[u] = ilk_reg ? match[0][dppg_pkg::CMP_PHASE] : match[u][dppg_pkg::CMP_PERIOD]; // R11 R15
			end else begin : g_own_tick
				assign tick[u] = own_tick;
				assign clr_match[u] = match[u][dppg_pkg::CMP_PERIOD]; // R12
			end

			// period end: clear by match, or wrap of a free running counter
			assign period_end[u] = ctl_reg[u].run && tick[u] &&
				(ctl_reg[u].cle ? clr_match[u] : (cnt_reg[u] == {CNT_W{1'b1}}));
			assign xfer[u] = ctl_reg[u].bufm && ctl_reg[u].upd && period_end[u]; // R18 R21

			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					pre_reg[u] <= '0;
				end else begin
					pre_reg[u] <= pre_reg[u] + 1'b1;
				end
			end

			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					ctl_reg[u] <= dppg_pkg::CTL_RST;
				end else begin
					if (wsel && hit_run) begin
						ctl_reg[u].run <= pwdata_i[dppg_pkg::RUN_BIT]; // R8
					end
					if (wsel && hit_mod) begin
						ctl_reg[u].cle <= pwdata_i[dppg_pkg::CLE_BIT];
						ctl_reg[u].sel <= pwdata_i[dppg_pkg::SEL_LSB +: dppg_pkg::SEL_W];
					end
					if (wsel && hit_cr) begin
						ctl_reg[u].bufm <= pwdata_i[dppg_pkg::BUFM_BIT];
					end
					// a software set in the transfer cycle wins over the hardware clear
					if (wsel && hit_cr) begin
						ctl_reg[u].upd <= pwdata_i[dppg_pkg::UPD_BIT];
					end else if (xfer[u]) begin
						ctl_reg[u].upd <= 1'b0; // R21
					end
				end
			end

			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i || !ctl_reg[u].run) begin
					cnt_reg[u] <= '0; // R8
				end else if (tick[u]) begin
					if (ctl_reg[u].cle && clr_match[u]) begin
						cnt_reg[u] <= '0; // R10 R11
					end else begin
						cnt_reg[u] <= cnt_reg[u] + 1'b1; // R7 R9
					end
				end
			end

			for (m = 0; m < dppg_pkg::CMP_MAX; m++) begin : g_cmp
				if (m < NCMP) begin : g_live
					localparam bit IS_MOD = (m == 2) || (m == 4);
					localparam logic [19:0] MASK = IS_MOD ? dppg_pkg::MASK_MOD :
						((m == dppg_pkg::CMP_PHASE) ? dppg_pkg::MASK_PHASE : dppg_pkg::MASK_PLAIN);
					wire wr_rg = wsel && hit_rg && (idx == 3'(m));
					wire [16:0] cmp_val = IS_MOD ? {1'b0, cp_reg[u][m][19:4]} : cp_reg[u][m][16:0];
					wire raw = ctl_reg[u].run && tick[u] && (cmp_val == {1'b0, cnt_reg[u]}); // R22

					always_ff @(posedge core_clk_i) begin
						if (!rst_n_i) begin
							rg_reg[u][m] <= '0;
							cp_reg[u][m] <= '0;
						end else begin
							if (wr_rg) begin
								rg_reg[u][m] <= pwdata_i[19:0] & MASK;
							end
							// the compare side has no write path of its own
							if (wr_rg && !ctl_reg[u].bufm) begin
								cp_reg[u][m] <= pwdata_i[19:0] & MASK; // R16 R17 R2
							end else if (xfer[u]) begin
								cp_reg[u][m] <= rg_reg[u][m]; // R18 R2
							end
						end
					end

					if (IS_MOD) begin : g_mod
						logic [dppg_pkg::RATE_W-1:0] acc_reg;
						logic shift_reg;
						logic raw_d_reg;
						wire [dppg_pkg::RATE_W:0] acc_sum = {1'b0, acc_reg} +
							{1'b0, cp_reg[u][m][dppg_pkg::RATE_W-1:0]}; // R20
						always_ff @(posedge core_clk_i) begin
							if (!rst_n_i || !ctl_reg[u].run) begin
								acc_reg <= '0;
								shift_reg <= 1'b0;
								raw_d_reg <= 1'b0;
							end else begin
								raw_d_reg <= raw;
								// rate out of sixteen periods get the one clock shift
								if (period_end[u]) begin
									acc_reg <= acc_sum[dppg_pkg::RATE_W-1:0];
									shift_reg <= acc_sum[dppg_pkg::RATE_W];
								end
							end
						end
						assign match[u][m] = shift_reg ? raw_d_reg : raw; // R19
					end else begin : g_plain
						assign match[u][m] = raw;
					end
				end else begin : g_none
					assign match[u][m] = 1'b0;
					always_ff @(posedge core_clk_i) begin
						rg_reg[u][m] <= '0;
						cp_reg[u][m] <= '0;
					end
				end
			end

			// ch0 rises on comparator 1, falls on 2; ch1 rises on 3, falls on 4
			for (m = 0; m < 2; m++) begin : g_ch
				always_ff @(posedge core_clk_i) begin
					if (!rst_n_i || !ctl_reg[u].run) begin
						wave_reg[u][m] <= 1'b0;
					end else if (match[u][2 * m + 2]) begin
						wave_reg[u][m] <= 1'b0; // R14
					end else if (match[u][2 * m + 1]) begin
						wave_reg[u][m] <= 1'b1; // R13
					end
				end
			end
		end
	endgenerate

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign wave_o = {wave_reg[1], wave_reg[0]};
endmodule : dppg_timer

// ===== test/dppg_load.sv
// load model that measures high time and period of one wave output
`timescale 1ns/100ps
module dppg_load (
	input wire logic clk_i, // clock
	input wire logic wave_i, // wave level
	output logic [15:0] width_o, // last high time in cycles
	output logic [15:0] period_o // last rise to rise time
);
	logic [15:0] hi_reg;
	logic [15:0] per_reg;
	logic last_reg;
	always_ff @(posedge clk_i) begin
		last_reg <= wave_i;
		hi_reg <= wave_i ? hi_reg + 16'h1 : 16'h0;
		per_reg <= (wave_i && !last_reg) ? 16'h1 : per_reg + 16'h1;
		if (!wave_i && last_reg) width_o <= hi_reg;
		if (wave_i && !last_reg) period_o <= per_reg;
	end
endmodule : dppg_load

// ===== test/dppg_timer_assertions.sv
// port checker for the rectangular wave timer
`timescale 1ns/100ps
module dppg_timer_assertions #(
	parameter int CNT_W = 16
) (
	input wire logic core_clk_i, // clock
	input wire logic rst_n_i, // reset, active low
	input wire logic psel_i, // select
	input wire logic penable_i, // enable
	input wire logic pwrite_i, // write
	input wire logic [11:0] paddr_i, // address
	input wire logic [31:0] pwdata_i, // write data
	input wire logic [31:0] prdata_o, // read data
	input wire logic pready_o, // ready
	input wire logic pslverr_o, // error
	input wire logic [3:0] wave_o // wave outputs
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	wire rd_w = pready_o && !pwrite_i;
	ready_setup_a: assert property (psel_i && !penable_i |=> pready_o) else $error("setup not answered");
	ready_cause_a: assert property (pready_o |-> $past(psel_i && !penable_i)) else $error("ready without setup");
	rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside access");
	err_idle_a: assert property (!pready_o |-> !pslverr_o) else $error("error outside access");
	phase_upper_a: assert property (rd_w && paddr_i == 12'h054 |-> prdata_o[31:17] == 15'h0)
		else $error("phase upper bits set");
	rate_upper_a: assert property (rd_w && paddr_i[7:0] == 8'h48 |-> prdata_o[31:20] == 12'h0)
		else $error("compare two upper bits set");
	unit_gap_a: assert property (pready_o && paddr_i inside {12'h134, 12'h154} |-> pslverr_o)
		else $error("unit one index five mapped");
	phase_mapped_a: assert property (pready_o && paddr_i == 12'h054 |-> !pslverr_o)
		else $error("phase compare refused");
	cover property (pready_o && pwrite_i && paddr_i == 12'h054);
	cover property (pslverr_o);
	cover property ($rose(wave_o[2]));
endmodule : dppg_timer_assertions
bind dppg_timer dppg_timer_assertions #(.CNT_W(CNT_W)) u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .wave_o(wave_o));

// ===== test/dppg_timer_tb.sv
// self-checking bench for the rectangular wave timer
`timescale 1ns/100ps
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", nm, exp, got); end end
module dppg_timer_tb;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic [3:0] wave_o;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	logic [31:0] v;
	logic [15:0] w0, p0, w2, p2;
	int miscompares = 0;
	int check_count = 0;
	dppg_timer dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .wave_o(wave_o));
	dppg_load u_ld0 (.clk_i(core_clk_i), .wave_i(wave_o[0]), .width_o(w0), .period_o(p0));
	dppg_load u_ld2 (.clk_i(core_clk_i), .wave_i(wave_o[2]), .width_o(w2), .period_o(p2));
	initial begin
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	task print_verdict;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	// x holds {compare data, expected error, expected data}
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] x);
		int n;
		n = 0;
		@(posedge core_clk_i);
		exp_q.push_back(x);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 8);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 8) begin
			miscompares++;
			print_verdict();
		end
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, {2'b00, 32'h0});
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0, {2'b10, x});
	endtask : rd
	always @(posedge core_clk_i) begin
		if (rst_n_i && psel_i && penable_i && pready_o === 1'b1) begin
			e = exp_q.pop_front();
			`CHK("pslverr", pslverr_o, e[32])
			if (e[33]) `CHK("prdata", prdata_o, e[31:0])
		end
	end
	initial begin
		repeat (20000) @(posedge core_clk_i);
		miscompares++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h48C22642));
		repeat (10) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd(12'h054, 32'h0);
		rd(12'h048, 32'h0);
		v = $urandom();
		wr(12'h034, v);
		rd(12'h054, {15'h0, v[16:0]});
		wr(12'h054, ~v);
		rd(12'h054, {15'h0, v[16:0]});
		xfer(1'b1, 12'h134, v, {2'b01, 32'h0});
		xfer(1'b0, 12'h154, 32'h0, {2'b11, 32'h0});
		$display("registers test done");
		wr(12'h034, 32'h3);
		wr(12'h004, 32'h10);
		wr(12'h020, 32'h9);
		wr(12'h024, 32'h2);
		wr(12'h028, 32'h60);
		wr(12'h104, 32'h13);
		wr(12'h124, 32'h2);
		wr(12'h128, 32'h60);
		wr(12'h200, 32'h1);
		wr(12'h000, 32'h1);
		wr(12'h100, 32'h1);
		repeat (60) @(posedge core_clk_i);
		`CHK("width0", w0, 16'h4)
		`CHK("period0", p0, 16'hA)
		`CHK("width2", w2, 16'h4)
		`CHK("period2", p2, 16'hA)
		$display("interlock test done");
		wr(12'h008, 32'h1);
		wr(12'h024, 32'h3);
		rd(12'h044, 32'h2);
		wr(12'h008, 32'h3);
		repeat (25) @(posedge core_clk_i);
		rd(12'h044, 32'h3);
		rd(12'h008, 32'h1);
		$display("buffered test done");
		wr(12'h004, 32'h11);
		repeat (120) @(posedge core_clk_i);
		`CHK("width0", w0, 16'h6)
		`CHK("period0", p0, 16'h14)
		`CHK("width2", w2, 16'h8)
		`CHK("period2", p2, 16'h14)
		`CHK("ch1", {wave_o[3], wave_o[1]}, 2'b00)
		$display("prescaler test done");
		print_verdict();
	end
endmodule : dppg_timer_tb
